// ===== logic/txpm_params.svh
`ifndef TXPM_PARAMS_SVH
`define TXPM_PARAMS_SVH

// Register offsets
`define TXPM_OFF_COUNT0 8'hd0
`define TXPM_OFF_COUNT1 8'hd1
`define TXPM_OFF_COUNT2 8'hd2
`define TXPM_OFF_COUNT3 8'hd3
`define TXPM_OFF_ERR 8'hd4
`define TXPM_OFF_UPD_REQ 8'hd6
`define TXPM_OFF_UPD_DONE 8'hd7
`define TXPM_OFF_LAPS_EN 8'hd8
`define TXPM_OFF_LAPS_ADDR 8'hd9
`define TXPM_OFF_LAPS_CTRL 8'hda
`define TXPM_OFF_IRQ_STAT 8'he0
`define TXPM_OFF_IRQ_MASK 8'he1

// Reset values
`define TXPM_RST_LAPS_ADDR 8'h04
`define TXPM_RST_LAPS_CTRL 8'h03

// Interrupt status bit positions
`define TXPM_IRQ_DONE 0
`define TXPM_IRQ_ADDR_BAD 1
`define TXPM_IRQ_CTRL_BAD 2
`define TXPM_IRQ_W 3

// Fill and flag octet
`define TXPM_FLAG 8'h7e

`endif

// ===== logic/txpm_pkg.sv
`default_nettype none
package txpm_pkg;

  typedef enum logic [1:0] {
    TXPM_IDLE = 2'h0,
    TXPM_HDR_CTRL = 2'h1,
    TXPM_BODY = 2'h3
  } txpm_tx_st_t;

  typedef struct packed {
    txpm_tx_st_t st;
    logic [7:0] sh;
    logic [2:0] bitc;
    logic ser;
    logic clean;
    logic bsync;
    logic [31:0] live;
    logic [31:0] snap;
    logic err_trig;
    logic req;
    logic done;
    logic laps;
    logic [7:0] addr;
    logic [7:0] ctrl;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic rxd_s1;
    logic rxd_s2;
    logic rxb_s1;
    logic rxb_s2;
    logic rxf_s1;
    logic rxf_s2;
    logic [7:0] rx_sh;
    logic [2:0] rx_bitc;
    logic [1:0] rx_pos;
  } txpm_state_t;

endpackage
`default_nettype wire

// ===== logic/txpm_top.sv
// What this block does
// - Keep a 32-bit count of sent packet bytes, readable as four bytes.
// - Each rising edge of the error bit inverts exactly one sent bit.
// - Rising update bit copies live counters to snapshot, restarts live ones.
// - Raise the update done flag once the snapshot has been taken.
// - Clear the update done flag when software clears the update bit.
// - One enable bit turns on encapsulation for transmit and receive together.
// - Transmit wraps each frame in a header; receive checks incoming headers.
// - In encapsulation mode no HDLC opening flag framing is applied.
// - In encapsulation mode mark each sent byte's first bit on sync out.
// - Programmed address goes in each sent header, expected on receive.
// - Programmed control goes in each sent header, expected on receive.
`timescale 1ns/10ps
`include "txpm_params.svh"
`default_nettype none
module txpm_top (
  input wire logic clk, // 125 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  output logic irq, // Level interrupt
  input wire logic [7:0] pkt_data, // Packet byte to send
  input wire logic pkt_valid, // Packet byte present
  input wire logic pkt_last, // Last byte of frame
  output logic pkt_ready, // Byte taken this cycle
  output logic tx_serial_out, // Serial transmit data
  output logic tx_byte_boundary_out, // First bit of a sent byte
  input wire logic rx_serial_in, // Serial receive data pin
  input wire logic rx_byte_boundary_in, // First bit of a received byte
  input wire logic rx_frame_start_in // First byte of a received frame
);

  txpm_pkg::txpm_state_t q;
  txpm_pkg::txpm_state_t d;

  logic load;
  logic take;
  logic upd_rise;
  logic err_rise;
  logic rx_byte_done;
  logic [7:0] rx_byte;
  logic [7:0] next_byte;
  logic [2:0] events;
  logic [2:0] w1c;
  logic [31:0] live_inc;

  always_comb
  begin
    d = q;
    load = (q.bitc == 3'h0);
    take = 1'b0;
    next_byte = `TXPM_FLAG;
    upd_rise = 1'b0;
    err_rise = 1'b0;
    events = 3'h0;
    w1c = 3'h0;
    live_inc = q.live;

    // Transmit framer, one byte fetched every eighth bit
    if (load)
    begin
      case (q.st)
        txpm_pkg::TXPM_IDLE:
        begin
          if (pkt_valid)
          begin
            if (q.laps)
            begin
              next_byte = q.addr;
              d.st = txpm_pkg::TXPM_HDR_CTRL;
            end
            else
            begin
              // Opening flag only outside encapsulation mode
              next_byte = `TXPM_FLAG;
              d.st = txpm_pkg::TXPM_BODY;
            end
          end
        end
        txpm_pkg::TXPM_HDR_CTRL:
        begin
          next_byte = q.ctrl;
          d.st = txpm_pkg::TXPM_BODY;
        end
        txpm_pkg::TXPM_BODY:
        begin
          // Underrun sends fill rather than stalling the line
          if (pkt_valid)
          begin
            take = 1'b1;
            next_byte = pkt_data;
            if (pkt_last)
            begin
              d.st = txpm_pkg::TXPM_IDLE;
            end
          end
        end
        default:
        begin
          d.st = txpm_pkg::TXPM_IDLE;
        end
      endcase
      d.sh = next_byte;
    end
    else
    begin
      d.sh = {q.sh[6:0], 1'b0};
    end
    d.bitc = q.bitc + 3'h1;
    d.bsync = load & q.laps;

    if (take)
    begin
      live_inc = q.live + 32'h1;
    end

    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == `TXPM_OFF_ERR)
      begin
        err_rise = reg_wdata[0] & ~q.err_trig;
        d.err_trig = reg_wdata[0];
      end
      else if (reg_addr == `TXPM_OFF_UPD_REQ)
      begin
        upd_rise = reg_wdata[0] & ~q.req;
        d.req = reg_wdata[0];
      end
      else if (reg_addr == `TXPM_OFF_LAPS_EN)
      begin
        d.laps = reg_wdata[0];
      end
      else if (reg_addr == `TXPM_OFF_LAPS_ADDR)
      begin
        d.addr = reg_wdata;
      end
      else if (reg_addr == `TXPM_OFF_LAPS_CTRL)
      begin
        d.ctrl = reg_wdata;
      end
      else if (reg_addr == `TXPM_OFF_IRQ_STAT)
      begin
        w1c = reg_wdata[2:0];
      end
      else if (reg_addr == `TXPM_OFF_IRQ_MASK)
      begin
        d.irq_mask = reg_wdata[2:0];
      end
    end

    // Byte sent in the update cycle stays in the new period
    if (upd_rise)
    begin
      d.snap = q.live;
      d.live = take ? 32'h1 : 32'h0;
    end
    else
    begin
      d.live = live_inc;
    end
    d.done = d.req & q.req;

    // Error bit rides on the bit sent at the write edge
    d.clean = load ? next_byte[7] : q.sh[6];
    d.ser = d.clean ^ err_rise;

    // Receive side: sync pins, then assemble bytes on line boundaries
    d.rxd_s1 = rx_serial_in;
    d.rxd_s2 = q.rxd_s1;
    d.rxb_s1 = rx_byte_boundary_in;
    d.rxb_s2 = q.rxb_s1;
    d.rxf_s1 = rx_frame_start_in;
    d.rxf_s2 = q.rxf_s1;
    d.rx_sh = {q.rx_sh[6:0], q.rxd_s2};
    d.rx_bitc = q.rxb_s2 ? 3'h1 : q.rx_bitc + 3'h1;
    rx_byte = {q.rx_sh[6:0], q.rxd_s2};
    rx_byte_done = (q.rx_bitc == 3'h7) & ~q.rxb_s2;
    if (q.rxf_s2)
    begin
      d.rx_pos = 2'h0;
    end
    else if (rx_byte_done && q.rx_pos != 2'h2)
    begin
      d.rx_pos = q.rx_pos + 2'h1;
    end
    if (rx_byte_done && q.laps && !q.rxf_s2)
    begin
      events[`TXPM_IRQ_ADDR_BAD] = (q.rx_pos == 2'h0) &&
        (rx_byte != q.addr);
      events[`TXPM_IRQ_CTRL_BAD] = (q.rx_pos == 2'h1) &&
        (rx_byte != q.ctrl);
    end
    events[`TXPM_IRQ_DONE] = d.done & ~q.done;

    // New event wins over a clear in the same cycle
    d.irq_st = (q.irq_st & ~w1c) | events;

    // Register reads
    d.rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == `TXPM_OFF_COUNT0)
      begin
        d.rdata = q.snap[7:0];
      end
      else if (reg_addr == `TXPM_OFF_COUNT1)
      begin
        d.rdata = q.snap[15:8];
      end
      else if (reg_addr == `TXPM_OFF_COUNT2)
      begin
        d.rdata = q.snap[23:16];
      end
      else if (reg_addr == `TXPM_OFF_COUNT3)
      begin
        d.rdata = q.snap[31:24];
      end
      else if (reg_addr == `TXPM_OFF_ERR)
      begin
        d.rdata = {7'h00, q.err_trig};
      end
      else if (reg_addr == `TXPM_OFF_UPD_REQ)
      begin
        d.rdata = {7'h00, q.req};
      end
      else if (reg_addr == `TXPM_OFF_UPD_DONE)
      begin
        d.rdata = {7'h00, q.done};
      end
      else if (reg_addr == `TXPM_OFF_LAPS_EN)
      begin
        d.rdata = {7'h00, q.laps};
      end
      else if (reg_addr == `TXPM_OFF_LAPS_ADDR)
      begin
        d.rdata = q.addr;
      end
      else if (reg_addr == `TXPM_OFF_LAPS_CTRL)
      begin
        d.rdata = q.ctrl;
      end
      else if (reg_addr == `TXPM_OFF_IRQ_STAT)
      begin
        d.rdata = {5'h00, q.irq_st};
      end
      else if (reg_addr == `TXPM_OFF_IRQ_MASK)
      begin
        d.rdata = {5'h00, q.irq_mask};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= txpm_pkg::TXPM_IDLE;
      q.addr <= `TXPM_RST_LAPS_ADDR;
      q.ctrl <= `TXPM_RST_LAPS_CTRL;
      // No header check on line junk before the first frame start
      q.rx_pos <= 2'h2;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq = |(q.irq_st & q.irq_mask);
  assign pkt_ready = take;
  assign tx_serial_out = q.ser;
  assign tx_byte_boundary_out = q.bsync;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence hdr_start_s;
    load && q.st == txpm_pkg::TXPM_IDLE && pkt_valid && q.laps;
  endsequence

  sequence hdr_bytes_s;
    (q.sh == $past(q.addr)) ##8 (q.sh == $past(q.ctrl, 9));
  endsequence

  count_step_a: assert property (
    $past(take) && !$rose(q.req) |-> q.live == $past(q.live) + 32'h1)
    else $error("byte count did not advance");

  err_one_a: assert property (
    $rose(q.err_trig) |-> q.ser != q.clean)
    else $error("error bit not inserted");

  err_none_a: assert property (
    !$rose(q.err_trig) |-> q.ser == q.clean)
    else $error("unexpected bit corruption");

  snap_take_a: assert property (
    $rose(q.req) |-> q.snap == $past(q.live) && q.live <= 32'h1)
    else $error("snapshot or restart wrong");

  done_set_a: assert property (
    $rose(q.req) ##1 q.req |-> q.done)
    else $error("done flag not raised");

  done_clear_a: assert property (
    !q.req |-> !q.done)
    else $error("done flag stuck after request cleared");

  hdr_send_a: assert property (
    hdr_start_s |=> hdr_bytes_s)
    else $error("header bytes not sent");

  no_flag_a: assert property (
    hdr_start_s |=> q.st == txpm_pkg::TXPM_HDR_CTRL)
    else $error("flag framing used in encapsulation mode");

  bsync_mark_a: assert property (
    q.bsync |-> $past(q.laps) && q.bitc == 3'h1)
    else $error("byte boundary mark misplaced");

  count_hold_a: assert property (
    !$past(take) && !$rose(q.req) |-> $stable(q.live))
    else $error("byte count moved without a byte");

  rx_addr_a: assert property (
    rx_byte_done && q.laps && !q.rxf_s2 && q.rx_pos == 2'h0 &&
    rx_byte != q.addr |=> q.irq_st[`TXPM_IRQ_ADDR_BAD])
    else $error("address mismatch not flagged");

  rx_ctrl_a: assert property (
    rx_byte_done && q.laps && !q.rxf_s2 && q.rx_pos == 2'h1 &&
    rx_byte != q.ctrl |=> q.irq_st[`TXPM_IRQ_CTRL_BAD])
    else $error("control mismatch not flagged");

endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [7:0] pkt_data = 8'h00;
  logic pkt_valid = 1'h0;
  logic pkt_last = 1'h0;
  logic pkt_ready;
  logic tx_serial_out;
  logic tx_byte_boundary_out;
  logic rx_serial_in;
  logic rx_byte_boundary_in;
  logic rx_frame_start_in;
  int errors = 0;
  int cmp_count = 0;
  txpm_top txpm_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .pkt_data(pkt_data),
    .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
    .tx_serial_out(tx_serial_out),
    .tx_byte_boundary_out(tx_byte_boundary_out),
    .rx_serial_in(rx_serial_in), .rx_byte_boundary_in(rx_byte_boundary_in),
    .rx_frame_start_in(rx_frame_start_in));
  txpm_line_model txpm_line_model_i (.clk(clk), .tx_bit(tx_serial_out),
    .tx_sync(tx_byte_boundary_out), .rx_bit(rx_serial_in),
    .rx_sync(rx_byte_boundary_in), .rx_start(rx_frame_start_in));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: flag %b want %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk8(reg_rdata, e);
  endtask
  task automatic pkt(input logic [7:0] d, input logic l);
    @(posedge clk);
    pkt_data <= d;
    pkt_last <= l;
    pkt_valid <= 1'h1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk);
      if (pkt_ready === 1'h1)
        break;
    end
    chk1(pkt_ready, 1'h1);
    @(posedge clk);
    pkt_valid <= 1'h0;
  endtask
  task automatic t_reset;
    rdc(8'hd9, 8'h04);
    rdc(8'hda, 8'h03);
    rdc(8'hd2, 8'h00);
    wr(8'hd3, 8'hff);
    rdc(8'hd3, 8'h00);
    rdc(8'hd7, 8'h00);
    rdc(8'hd8, 8'h00);
    rdc(8'hc5, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_laps;
    int i;
    wr(8'hd9, 8'h5a);
    wr(8'hda, 8'h3c);
    wr(8'hd8, 8'h01);
    repeat (20) @(posedge clk);
    txpm_line_model_i.got_q.delete();
    pkt(8'ha1, 1'h0);
    pkt(8'hb2, 1'h1);
    repeat (40) @(posedge clk);
    i = 0;
    while (i < txpm_line_model_i.got_q.size() &&
           txpm_line_model_i.got_q[i] !== 8'h5a)
      i++;
    chk8(txpm_line_model_i.got_q[i], 8'h5a);
    chk8(txpm_line_model_i.got_q[i + 1], 8'h3c);
    chk8(txpm_line_model_i.got_q[i + 2], 8'ha1);
    chk8(txpm_line_model_i.got_q[i + 3], 8'hb2);
    $display("test laps transmit done");
  endtask
  task automatic t_snap;
    wr(8'he1, 8'h01);
    wr(8'hd6, 8'h01);
    rdc(8'hd7, 8'h01);
    rdc(8'hd0, 8'h02);
    rdc(8'hd2, 8'h00);
    chk1(irq, 1'h1);
    wr(8'he0, 8'h01);
    chk1(irq, 1'h0);
    wr(8'hd6, 8'h00);
    rdc(8'hd7, 8'h00);
    wr(8'he1, 8'h00);
    wr(8'hd6, 8'h01);
    rdc(8'hd0, 8'h00);
    chk1(irq, 1'h0);
    wr(8'hd6, 8'h00);
    wr(8'he0, 8'h07);
    $display("test snapshot done");
  endtask
  task automatic t_err;
    int n;
    n = 0;
    txpm_line_model_i.got_q.delete();
    wr(8'hd4, 8'h01);
    wr(8'hd4, 8'h01);
    repeat (40) @(posedge clk);
    foreach (txpm_line_model_i.got_q[k])
      n += $countones(txpm_line_model_i.got_q[k] ^ 8'h7e);
    chk8(n[7:0], 8'h01);
    wr(8'hd4, 8'h00);
    $display("test error insert done");
  endtask
  task automatic t_rx;
    txpm_line_model_i.send(8'h5a, 8'h3c);
    rdc(8'he0, 8'h00);
    txpm_line_model_i.send(8'h5b, 8'h3c);
    rdc(8'he0, 8'h02);
    wr(8'he0, 8'h02);
    txpm_line_model_i.send(8'h5a, 8'h3d);
    rdc(8'he0, 8'h04);
    wr(8'he0, 8'h04);
    wr(8'hd8, 8'h00);
    txpm_line_model_i.send(8'h11, 8'h22);
    rdc(8'he0, 8'h00);
    $display("test laps receive done");
  endtask
  task automatic t_hdlc;
    logic [15:0] w;
    logic seen;
    w = 16'h0000;
    seen = 1'h0;
    fork
      pkt(8'hc3, 1'h1);
      repeat (40)
      begin
        @(negedge clk);
        chk1(tx_byte_boundary_out, 1'h0);
        w = {w[14:0], tx_serial_out};
        seen = seen | (w == 16'h7ec3);
      end
    join
    // Plain mode puts the opening flag right before the payload
    chk1(seen, 1'h1);
    $display("test plain framing done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    wrap_up();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    t_reset();
    t_laps();
    t_snap();
    t_err();
    t_rx();
    t_hdlc();
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== testbench/txpm_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module txpm_line_model (
  input wire logic clk, // Bit clock
  input wire logic tx_bit, // Sent serial data
  input wire logic tx_sync, // Sent byte start
  output logic rx_bit, // Received serial data
  output logic rx_sync, // Received byte start
  output logic rx_start // Received frame start
);
  logic [7:0] sh = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic idle = 1'h1;
  logic [7:0] got_q[$];
  initial
  begin
    rx_bit = 1'h0;
    rx_sync = 1'h0;
    rx_start = 1'h0;
  end
  // Bytes are only framed by the sync pulse; unsynced bits are junk
  always @(posedge clk)
  begin
    sh = {sh[6:0], tx_bit};
    cnt = tx_sync ? 4'h1 : cnt + 4'h1;
    if (cnt == 4'h8)
      got_q.push_back(sh);
  end
  // Between frames the data line wiggles so stale values never match
  always @(posedge clk)
    if (idle)
      rx_bit <= ~rx_bit;
  task automatic send(input logic [7:0] a, input logic [7:0] c);
    logic [15:0] w;
    w = {a, c};
    idle = 1'h0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      rx_bit <= w[15 - i];
      rx_sync <= (i % 8 == 0);
      rx_start <= (i == 0);
    end
    @(posedge clk);
    rx_sync <= 1'h0;
    rx_start <= 1'h0;
    idle = 1'h1;
    // Last byte needs the two sync stages before its check lands
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire
